// ---- verilog/shtsa_pkg.sv ----
// Package: shared types and constants for the shared hub arbiter.
// Assumes one 200 MHz core clock; the hub steps on every other edge.
package shtsa_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CORES = 8;
    localparam int unsigned CORE_W = 3;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned LONG_AW = 14;
    localparam int unsigned MEM_LONGS = 16384;
    localparam int unsigned SLOT_PERIOD_CLKS = 16;
    localparam int unsigned MIN_HUB_CLKS = 7;
    localparam int unsigned MAX_HUB_CLKS = 22;
    localparam int unsigned FREE_CLKS = 9;
    localparam logic [7:0] CLKSEL_RESET = 8'h00;
    localparam logic [CORE_W-1:0] SLOT_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SHTSA_OP_NONE = 3'h0,
        SHTSA_OP_READ_BYTE = 3'h1,
        SHTSA_OP_READ_HALF = 3'h2,
        SHTSA_OP_READ_LONG = 3'h3,
        SHTSA_OP_WRITE_BYTE = 3'h4,
        SHTSA_OP_WRITE_HALF = 3'h5,
        SHTSA_OP_WRITE_LONG = 3'h6,
        SHTSA_OP_CLOCK_SELECT = 3'h7
    } shtsa_op_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        shtsa_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
    } shtsa_req_t;

    typedef struct packed {
        logic done;
        logic [31:0] data;
    } shtsa_rsp_t;

endpackage

// ---- verilog/shtsa_mem.sv ----
// Holds: the shared 16K x 32 main memory with byte lane writes.
// Assumes one access per cycle; read data is ready one edge later.
`timescale 1ns/1ps
module shtsa_mem (
    input wire logic core_clk_i,
    input wire logic we_i,
    input wire logic [3:0] be_i,
    input wire logic [shtsa_pkg::LONG_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [shtsa_pkg::MEM_LONGS];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (we_i && be_i[b]) begin
                mem[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// ---- verilog/shtsa_top.sv ----
// Holds: the time-slot hub arbiter for eight cores and its shared state.
// Assumes each core holds its request stable until it sees done.
//
// Function
// - Hub steps at half core clock; each core slotted every 16 clocks.
// - A requesting core stalls until its own slot comes round.
// - Hub operations complete between 7 and 22 core clocks.
// - After completion, nine free clocks, then next takes 7 clocks.
// - Two 4-clock instructions between hub operations give 8 clocks.
// - Only memory and clock select operations route here.
// - 64K byte shared memory as bytes, halfwords or longs.
// - Byte and halfword reads zero-extend; long reads return all bits.
// - Writes store low 8, 16 or all 32 bits at source address.
// - Accesses are aligned to their size.
// - One global clock select register shared by all cores.
// - Clock select write copies low eight data bits.
`timescale 1ns/1ps
module shtsa_top (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire shtsa_pkg::shtsa_req_t [7:0] req_i,
    output shtsa_pkg::shtsa_rsp_t [7:0] rsp_o,
    output logic [7:0] clock_select_o,
    output logic [2:0] slot_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SHTSA_PH_IDLE,
        SHTSA_PH_READ,
        SHTSA_PH_WRITE
    } shtsa_phase_t;

    typedef struct packed {
        logic half;
        logic [shtsa_pkg::CORE_W-1:0] slot;
        shtsa_phase_t phase;
        logic [shtsa_pkg::CORE_W-1:0] owner;
        shtsa_pkg::shtsa_op_t op;
        logic [1:0] lane;
        logic [7:0] clksel;
        shtsa_pkg::shtsa_rsp_t [7:0] rsp;
    } shtsa_state_t;

    shtsa_state_t s_q;
    shtsa_state_t s_d;

    shtsa_pkg::shtsa_req_t cur;
    logic mem_we;
    logic [3:0] mem_be;
    logic [shtsa_pkg::LONG_AW-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;

    // ------------------------------------------------------------------
    // Lane helpers
    // ------------------------------------------------------------------
    // Lane 0 is bits 7:0; the low address bits pick the lane
    function automatic logic [31:0] shtsa_read_pick(
        input shtsa_pkg::shtsa_op_t op,
        input logic [1:0] lane,
        input logic [31:0] word
    );
        logic [31:0] r;
        r = word;
        case (op)
            shtsa_pkg::SHTSA_OP_READ_BYTE: begin
                case (lane)
                    2'h0: r = {24'h000000, word[7:0]};
                    2'h1: r = {24'h000000, word[15:8]};
                    2'h2: r = {24'h000000, word[23:16]};
                    default: r = {24'h000000, word[31:24]};
                endcase
            end
            shtsa_pkg::SHTSA_OP_READ_HALF: begin
                // Odd byte bit ignored; halfword stays on its boundary
                if (lane[1]) begin
                    r = {16'h0000, word[31:16]};
                end else begin
                    r = {16'h0000, word[15:0]};
                end
            end
            default: begin
                r = word;
            end
        endcase
        return r;
    endfunction

    // Data is copied to every lane, so the enables alone place it
    function automatic logic [3:0] shtsa_write_lanes(
        input shtsa_pkg::shtsa_op_t op,
        input logic [1:0] lane
    );
        logic [3:0] be;
        case (op)
            shtsa_pkg::SHTSA_OP_WRITE_BYTE: begin
                be = 4'h1 << lane;
            end
            shtsa_pkg::SHTSA_OP_WRITE_HALF: begin
                be = lane[1] ? 4'hC : 4'h3;
            end
            shtsa_pkg::SHTSA_OP_WRITE_LONG: begin
                be = 4'hF;
            end
            default: begin
                be = 4'h0;
            end
        endcase
        return be;
    endfunction

    function automatic logic [31:0] shtsa_write_copy(
        input shtsa_pkg::shtsa_op_t op,
        input logic [31:0] data
    );
        logic [31:0] w;
        case (op)
            shtsa_pkg::SHTSA_OP_WRITE_BYTE: begin
                w = {4{data[7:0]}};
            end
            shtsa_pkg::SHTSA_OP_WRITE_HALF: begin
                w = {2{data[15:0]}};
            end
            default: begin
                w = data;
            end
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Memory
    // ------------------------------------------------------------------
    shtsa_mem u_mem (
        .core_clk_i(core_clk_i),
        .we_i(mem_we),
        .be_i(mem_be),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        cur = req_i[s_q.slot];
        mem_we = 1'b0;
        mem_be = 4'h0;
        mem_addr = cur.addr[shtsa_pkg::ADDR_W-1:2];
        mem_wdata = 32'h0000_0000;
        for (int c = 0; c < 8; c++) begin
            s_d.rsp[c].done = 1'b0;
        end
        s_d.half = ~s_q.half;
        if (s_q.half) begin
            // Slot moves regardless of demand; keeps latency bounded
            s_d.slot = s_q.slot + 3'h1;
        end
        // Grant in the first half of a slot only to the slotted core
        if (!s_q.half && cur.valid && !s_q.rsp[s_q.slot].done) begin
            s_d.owner = s_q.slot;
            s_d.op = cur.op;
            s_d.lane = cur.addr[1:0];
            case (cur.op)
                shtsa_pkg::SHTSA_OP_READ_BYTE,
                shtsa_pkg::SHTSA_OP_READ_HALF,
                shtsa_pkg::SHTSA_OP_READ_LONG: begin
                    s_d.phase = SHTSA_PH_READ;
                end
                shtsa_pkg::SHTSA_OP_WRITE_BYTE,
                shtsa_pkg::SHTSA_OP_WRITE_HALF,
                shtsa_pkg::SHTSA_OP_WRITE_LONG: begin
                    mem_we = 1'b1;
                    mem_be = shtsa_write_lanes(cur.op, cur.addr[1:0]);
                    mem_wdata = shtsa_write_copy(cur.op, cur.data);
                    s_d.phase = SHTSA_PH_WRITE;
                end
                shtsa_pkg::SHTSA_OP_CLOCK_SELECT: begin
                    s_d.clksel = cur.data[7:0];
                    s_d.phase = SHTSA_PH_WRITE;
                end
                default: begin
                    s_d.phase = SHTSA_PH_IDLE;
                end
            endcase
        end else begin
            s_d.phase = SHTSA_PH_IDLE;
        end
        // Completion on the edge after grant: done pulses for one cycle
        case (s_q.phase)
            SHTSA_PH_READ: begin
                s_d.rsp[s_q.owner].done = 1'b1;
                s_d.rsp[s_q.owner].data =
                    shtsa_read_pick(s_q.op, s_q.lane, mem_rdata);
            end
            SHTSA_PH_WRITE: begin
                s_d.rsp[s_q.owner].done = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.slot <= shtsa_pkg::SLOT_RESET;
            s_q.clksel <= shtsa_pkg::CLKSEL_RESET;
            s_q.phase <= SHTSA_PH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_o = s_q.rsp;
    assign clock_select_o = s_q.clksel;
    assign slot_o = s_q.slot;
endmodule

// ---- dv/shtsa_props.sv ----
// Checker: port timing of the hub arbiter.
// Assumes one clock; bound to shtsa_top below.
`timescale 1ns/1ps
module shtsa_props (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire shtsa_pkg::shtsa_req_t [7:0] req_i,
    input wire shtsa_pkg::shtsa_rsp_t [7:0] rsp_o,
    input wire logic [7:0] clock_select_o,
    input wire logic [2:0] slot_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_step;
        !$stable(slot_o);
    endsequence
    property p_slot_hold; s_step |=> $stable(slot_o); endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot short");
    property p_slot_next; s_step |-> slot_o == $past(slot_o) + 3'h1; endproperty
    a_slot_next: assert property (p_slot_next) else $error("slot order");
    property p_slot_move; s_step |-> ##2 s_step; endproperty
    a_slot_move: assert property (p_slot_move) else $error("slot stuck");
    for (genvar c = 0; c < 8; c++) begin : g_core
        sequence s_take;
            s_step ##0 (slot_o == c && req_i[c].valid && !rsp_o[c].done
                && req_i[c].op != shtsa_pkg::SHTSA_OP_NONE);
        endsequence
        property p_answer; s_take |-> ##2 rsp_o[c].done; endproperty
        a_answer: assert property (p_answer) else $error("no answer");
        property p_src;
            rsp_o[c].done |-> $past(slot_o, 2) == c && $past(req_i[c].valid, 2);
        endproperty
        a_src: assert property (p_src) else $error("done off slot");
        property p_none;
            rsp_o[c].done |-> $past(req_i[c].op, 2) != shtsa_pkg::SHTSA_OP_NONE;
        endproperty
        a_none: assert property (p_none) else $error("idle op done");
        property p_clk;
            s_take ##0 req_i[c].op == shtsa_pkg::SHTSA_OP_CLOCK_SELECT
                |=> clock_select_o == $past(req_i[c].data[7:0]);
        endproperty
        a_clk: assert property (p_clk) else $error("clock select");
        property p_hold; !rsp_o[c].done |-> $stable(rsp_o[c].data); endproperty
        a_hold: assert property (p_hold) else $error("data moved");
    end
endmodule
bind shtsa_top shtsa_props u_props (.core_clk_i, .reset_n_i, .req_i, .rsp_o,
    .clock_select_o, .slot_o);

// ---- dv/shtsa_core.sv ----
// Core model: one hub request, held until done.
// Assumes start comes from the bench between edges.
`timescale 1ns/1ps
module shtsa_core (
    input wire logic core_clk_i,
    input wire logic start_i,
    input wire shtsa_pkg::shtsa_req_t cmd_i,
    input wire shtsa_pkg::shtsa_rsp_t rsp_i,
    output shtsa_pkg::shtsa_req_t req_o,
    output logic busy_o
);
    initial req_o = '0;
    assign busy_o = req_o.valid;
    always @(posedge core_clk_i) begin
        if (start_i) begin
            req_o <= cmd_i;
        end else if (rsp_i.done) begin
            // Released lines flip so stale values never pass
            req_o <= {1'b0, ~req_o[$bits(req_o)-2:0]};
        end
    end
endmodule

// ---- dv/tb.sv ----
// Bench: eight core models against the hub arbiter.
// Assumes the bound checker and shtsa_core.
`timescale 1ns/1ps
module tb;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] start = 8'h00;
    shtsa_pkg::shtsa_req_t [7:0] cmd = '0;
    wire shtsa_pkg::shtsa_req_t [7:0] req;
    wire shtsa_pkg::shtsa_rsp_t [7:0] rsp;
    wire logic [7:0] busy;
    wire logic [7:0] clock_select;
    wire logic [2:0] slot;
    // Core clocks spent around the hub wait: fetch, issue, write-back
    localparam int unsigned CORE_OVH = 4;
    localparam int unsigned N_MIN = shtsa_pkg::MIN_HUB_CLKS - CORE_OVH;
    localparam int unsigned N_MAX = shtsa_pkg::MAX_HUB_CLKS - CORE_OVH;
    localparam int unsigned N_PERIOD = shtsa_pkg::SLOT_PERIOD_CLKS - 1;
    // Idle clocks from one done to an issue that just meets the slot
    localparam int unsigned GAP_MIN = shtsa_pkg::FREE_CLKS + CORE_OVH - 1;
    int n_errors = 0, n_compared = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    shtsa_top dut (.core_clk_i, .reset_n_i, .req_i(req), .rsp_o(rsp),
        .clock_select_o(clock_select), .slot_o(slot));
    for (genvar c = 0; c < 8; c++) begin : g_core
        shtsa_core u_core (.core_clk_i, .start_i(start[c]), .cmd_i(cmd[c]),
            .rsp_i(rsp[c]), .req_o(req[c]), .busy_o(busy[c]));
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Falling-edge issue; n counts clocks until done is seen
    task automatic hub(int c, shtsa_pkg::shtsa_op_t op, logic [15:0] a,
            logic [31:0] d, output logic [31:0] q, output int n);
        int nxt;
        @(negedge core_clk_i);
        cmd[c] = '{1'b1, op, a, d};
        start[c] = 1'b1;
        @(negedge core_clk_i);
        start[c] = 1'b0;
        for (n = 1; rsp[c].done !== 1'b1; n++) begin
            if (n > 24) begin
                n_errors++;
                wrap_up();
            end
            @(negedge core_clk_i);
        end
        q = rsp[c].data;
        check("latency", 32'(n >= N_MIN && n <= N_MAX), 32'h1);
        nxt = (c + 1) % shtsa_pkg::NUM_CORES;
        check("slot", 32'(slot), 32'(nxt));
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_mem();
        logic [31:0] q;
        int n;
        hub(1, shtsa_pkg::SHTSA_OP_WRITE_LONG, 16'hFFFC, 32'h12345678, q, n);
        hub(2, shtsa_pkg::SHTSA_OP_READ_LONG, 16'hFFFC, 32'h0, q, n);
        check("long", q, 32'h12345678);
        hub(2, shtsa_pkg::SHTSA_OP_READ_BYTE, 16'hFFFD, 32'h0, q, n);
        check("byte", q, 32'h00000056);
        hub(2, shtsa_pkg::SHTSA_OP_READ_HALF, 16'hFFFF, 32'h0, q, n);
        check("half", q, 32'h00001234);
        hub(3, shtsa_pkg::SHTSA_OP_WRITE_BYTE, 16'hFFFE, 32'hFFFFFFAB, q, n);
        hub(4, shtsa_pkg::SHTSA_OP_WRITE_HALF, 16'hFFFD, 32'hFFFFCDEF, q, n);
        hub(5, shtsa_pkg::SHTSA_OP_READ_LONG, 16'hFFFF, 32'h0, q, n);
        check("merge", q, 32'h12ABCDEF);
        hub(6, shtsa_pkg::SHTSA_OP_CLOCK_SELECT, 16'h0, 32'h5A5A5AC3, q, n);
        check("clksel", 32'(clock_select), 32'h000000C3);
    endtask
    task automatic t_timing();
        logic [31:0] q;
        int n;
        hub(7, shtsa_pkg::SHTSA_OP_READ_LONG, 16'h0, 32'h0, q, n);
        hub(7, shtsa_pkg::SHTSA_OP_READ_LONG, 16'h0, 32'h0, q, n);
        check("period", 32'(n), 32'(N_PERIOD));
        repeat (GAP_MIN) @(negedge core_clk_i);
        hub(7, shtsa_pkg::SHTSA_OP_READ_LONG, 16'h0, 32'h0, q, n);
        check("fast", 32'(n), 32'(N_MIN));
        // Two 4-clock instructions use all but one free clock
        repeat (GAP_MIN - 1) @(negedge core_clk_i);
        hub(7, shtsa_pkg::SHTSA_OP_READ_LONG, 16'h0, 32'h0, q, n);
        check("paired", 32'(n), 32'(N_MIN + 1));
        repeat (GAP_MIN + 1) @(negedge core_clk_i);
        hub(7, shtsa_pkg::SHTSA_OP_READ_LONG, 16'h0, 32'h0, q, n);
        check("missed", 32'(n), 32'(N_MAX));
    endtask
    // All cores at once; an idle op must never be served
    task automatic t_all();
        @(negedge core_clk_i);
        cmd[0] = '{1'b1, shtsa_pkg::SHTSA_OP_NONE, 16'h0, 32'h0};
        for (int c = 1; c < 8; c++) begin
            cmd[c] = '{1'b1, shtsa_pkg::SHTSA_OP_READ_BYTE, 16'(c), 32'h0};
        end
        start = 8'hFF;
        @(negedge core_clk_i);
        start = 8'h00;
        repeat (20) @(negedge core_clk_i);
        check("served", 32'(busy), 32'h00000001);
    endtask
    initial begin
        repeat (20) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        t_mem();
        t_timing();
        t_all();
        wrap_up();
    end
endmodule
